//--- hdl/apis_consts.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef APIS_CONSTS_SVH
`define APIS_CONSTS_SVH

`define APIS_CLK_KHZ          10000
`define APIS_T_WAKE_FAST_US   100
`define APIS_T_WAKE_SLOW_US   2500
`define APIS_T_TEMP_CONV_US   2200
`define APIS_T_VOLT_CONV_US   1100
`define APIS_T_SHDN_MIN_US    5000
`define APIS_US_TO_CYC(us)    ((((us) * `APIS_CLK_KHZ) + 999) / 1000)

`define APIS_OFS_CMD          4'h0
`define APIS_OFS_STATUS       4'h1
`define APIS_OFS_RESULT       4'h2

`define APIS_CFG_REF_BIT      0
`define APIS_CFG_PM_LSB       1
`define APIS_CFG_PM_MSB       2
`define APIS_CFG_ZERO_LSB     3
`define APIS_CFG_ZERO_MSB     6
`define APIS_CFG_ZERO_VAL     4'h0
`define APIS_CONV_TAG_LSB     4
`define APIS_CONV_TAG_MSB     6
`define APIS_CONV_TAG_VAL     3'h2
`define APIS_CONV_SEL_MSB     3

`define APIS_ST_BUSY_BIT      0
`define APIS_ST_VALID_BIT     1
`define APIS_ST_BADSEL_BIT    2
`define APIS_ST_REF_BIT       3
`define APIS_ST_PM_LSB        4
`define APIS_ST_PM_MSB        5

`define APIS_RST_PM           2'h0
`define APIS_RST_REF          1'h0

`endif

//--- hdl/apis_pkg.sv
// Types shared by the power and input select control block
package apis_pkg;

	typedef enum logic [1:0] {
		APIS_PM_SHUTDOWN  = 2'h0,
		APIS_PM_STBY_PLUS = 2'h1,
		APIS_PM_STBY      = 2'h2,
		APIS_PM_NORMAL    = 2'h3
	} apis_pm_e;

	typedef enum logic [1:0] {
		APIS_MEAS_VOLT   = 2'h0,
		APIS_MEAS_SUPPLY = 2'h1,
		APIS_MEAS_TEMP   = 2'h2,
		APIS_MEAS_UNDEF  = 2'h3
	} apis_meas_e;

	typedef enum logic [3:0] {
		APIS_NODE_NONE            = 4'h0,
		APIS_NODE_ANALOG_IN_ZERO  = 4'h1,
		APIS_NODE_ANALOG_IN_ONE   = 4'h2,
		APIS_NODE_ANALOG_IN_TWO   = 4'h3,
		APIS_NODE_ANALOG_IN_THREE = 4'h4,
		APIS_NODE_ANALOG_IN_FOUR  = 4'h5,
		APIS_NODE_ANALOG_IN_COMMON = 4'h6,
		APIS_NODE_VDD_QUARTER     = 4'h7,
		APIS_NODE_GROUND          = 4'h8,
		APIS_NODE_DIODE_ANODE     = 4'h9,
		APIS_NODE_DIODE_CATHODE   = 4'hA
	} apis_node_e;

	typedef enum logic [4:0] {
		APIS_ST_IDLE  = 5'h01,
		APIS_ST_WAKE  = 5'h02,
		APIS_ST_VOLT  = 5'h04,
		APIS_ST_TEMP1 = 5'h08,
		APIS_ST_TEMP2 = 5'h10
	} apis_fsm_e;

	typedef struct packed {
		logic adc_core;
		logic osc;
		logic ref_buffer;
		logic ref_core;
		logic temp_circuit;
	} apis_power_s;

endpackage : apis_pkg

//--- hdl/apis_sel_decode.sv
// Input selector decode into measurement kind and multiplexer nodes
`timescale 1ns/1ps
module apis_sel_decode
	import apis_pkg::*;
(
	input  wire logic [3:0] input_select,
	output apis_meas_e      kind,
	output apis_node_e      node_pos,
	output apis_node_e      node_neg
);

	always_comb begin
		kind     = APIS_MEAS_VOLT;
		node_pos = APIS_NODE_NONE;
		node_neg = APIS_NODE_ANALOG_IN_COMMON;
		case (input_select)
			4'h0: node_pos = APIS_NODE_ANALOG_IN_ZERO;
			4'h1: node_pos = APIS_NODE_ANALOG_IN_ONE;
			4'h2: node_pos = APIS_NODE_ANALOG_IN_TWO;
			4'h3: node_pos = APIS_NODE_ANALOG_IN_THREE;
			4'h4: node_pos = APIS_NODE_ANALOG_IN_FOUR;
			4'h6: node_pos = APIS_NODE_ANALOG_IN_COMMON;
			4'h7: begin
				kind     = APIS_MEAS_TEMP;
				node_pos = APIS_NODE_DIODE_ANODE;
				node_neg = APIS_NODE_DIODE_CATHODE;
			end
			4'h8: begin
				node_pos = APIS_NODE_ANALOG_IN_ZERO;
				node_neg = APIS_NODE_ANALOG_IN_ONE;
			end
			4'h9: begin
				node_pos = APIS_NODE_ANALOG_IN_TWO;
				node_neg = APIS_NODE_ANALOG_IN_THREE;
			end
			4'hB: begin
				kind     = APIS_MEAS_SUPPLY;
				node_pos = APIS_NODE_VDD_QUARTER;
				node_neg = APIS_NODE_GROUND;
			end
			4'hC: begin
				kind     = APIS_MEAS_TEMP;
				node_pos = APIS_NODE_ANALOG_IN_ZERO;
				node_neg = APIS_NODE_ANALOG_IN_ONE;
			end
			4'hD: begin
				kind     = APIS_MEAS_TEMP;
				node_pos = APIS_NODE_ANALOG_IN_TWO;
				node_neg = APIS_NODE_ANALOG_IN_THREE;
			end
			default: begin
				kind     = APIS_MEAS_UNDEF;
				node_neg = APIS_NODE_NONE;
			end
		endcase
	end

endmodule : apis_sel_decode

//--- hdl/apis_cycle_timer.sv
// Loadable down counter that flags the last cycle of an interval
`timescale 1ns/1ps
module apis_cycle_timer
	import apis_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_value,
	output logic                  busy,
	output logic                  done
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             run;
	} apis_timer_state_s;

	apis_timer_state_s s_q;
	apis_timer_state_s s_d;

	always_comb begin
		s_d = s_q;
		if (load) begin
			s_d.cnt = load_value;
			s_d.run = 1'b1;
		end else if (s_q.run) begin
			s_d.cnt = s_q.cnt - 1'b1;
			if (s_q.cnt == CNT_W'(1))
				s_d.run = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign busy = s_q.run;
	assign done = s_q.run && (s_q.cnt == CNT_W'(1));

	a_timer_stops: assert property (@(posedge clk) disable iff (reset)
		done && !load |=> !busy)
		else $error("timer still running after done");

endmodule : apis_cycle_timer

//--- hdl/apis_ctrl.sv
// Power mode and input select control of the temperature and voltage ADC
//
// Overview of operation
// - Power bits pick shutdown, standby-plus, standby, normal
// - Standby-plus keeps reference buffer on, fast wake
// - External reference makes standby-plus equal standby, except temperature wake (fast vs slow)
// - Shutdown powers everything off, clears data
// - Selector decodes voltage inputs; some codes undefined
// - Codes 0111, 1100, 1101 start temperature
// - Supply monitor samples quarter supply against ground
// - Temperature runs two bias steps, then subtract
// - Temperature result in eighth-kelvin steps
// - Temperature always uses internal reference
// - Temperature conversion lasts 2.2ms
// - Config byte: power bits 2:1, reference bit 0
// - Conversion byte: tag 010, selector 3:0, starts
// - Power-up enters shutdown mode
`timescale 1ns/1ps
`include "apis_consts.svh"
module apis_ctrl
	import apis_pkg::*;
#(
	parameter int ADDR_W        = 4,
	parameter int DATA_W        = 16,
	parameter int SAMPLE_W      = 12,
	parameter int CNT_W         = 16,
	parameter int WAKE_FAST_CYC = `APIS_US_TO_CYC(`APIS_T_WAKE_FAST_US),
	parameter int WAKE_SLOW_CYC = `APIS_US_TO_CYC(`APIS_T_WAKE_SLOW_US),
	parameter int TEMP_CYC      = `APIS_US_TO_CYC(`APIS_T_TEMP_CONV_US),
	parameter int VOLT_CYC      = `APIS_US_TO_CYC(`APIS_T_VOLT_CONV_US)
) (
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	input  wire logic                reg_write,
	input  wire logic                reg_read,
	output logic      [DATA_W-1:0]   reg_rdata,
	input  wire logic [SAMPLE_W-1:0] adc_sample_data,
	input  wire logic                adc_sample_valid,
	output logic                     adc_sample_start,
	output logic                     bias_step_high,
	output logic                     ref_internal_sel,
	output logic      [3:0]          mux_pos,
	output logic      [3:0]          mux_neg,
	output logic                     adc_core_on,
	output logic                     osc_on,
	output logic                     ref_buffer_on,
	output logic                     ref_core_on,
	output logic                     temp_circuit_on,
	output logic                     conversion_strobe
);

	localparam int TEMP_HALF = TEMP_CYC / 2;

	typedef struct packed {
		apis_fsm_e             fsm;
		apis_pm_e              pm;
		logic                  ref_int;
		apis_meas_e            kind;
		apis_node_e            pos;
		apis_node_e            neg;
		apis_power_s           pwr;
		logic                  ref_int_sel;
		logic                  bias_high;
		logic                  sample_start;
		logic                  strobe;
		logic [SAMPLE_W-1:0]   capt;
		logic [SAMPLE_W-1:0]   phase1;
		logic [SAMPLE_W-1:0]   result;
		logic                  result_valid;
		logic                  is_temp;
		logic                  bad_sel;
		logic [DATA_W-1:0]     rdata;
		logic [CNT_W-1:0]      dwell;
	} apis_ctrl_state_s;

	apis_ctrl_state_s s_q;
	apis_ctrl_state_s s_d;

	apis_meas_e       dec_kind;
	apis_node_e       dec_pos;
	apis_node_e       dec_neg;
	logic             tmr_load;
	logic [CNT_W-1:0] tmr_value;
	logic             tmr_done;
	logic             go_conv;
	logic             finish;
	logic             use_int;
	logic             fast;
	logic             is_cfg;
	logic             is_conv;
	logic [SAMPLE_W-1:0] cap_now;

	// Power pattern held between conversions
	function automatic apis_power_s idle_power(apis_pm_e pm, logic ref_int);
		apis_power_s p;
		p = '0;
		case (pm)
			APIS_PM_NORMAL: begin
				p.adc_core   = 1'b1;
				p.osc        = 1'b1;
				p.ref_core   = 1'b1;
				p.ref_buffer = ref_int;
			end
			APIS_PM_STBY_PLUS: begin
				p.ref_core   = 1'b1;
				p.ref_buffer = ref_int;
			end
			APIS_PM_STBY: p.ref_core = 1'b1;
			default: p = '0;
		endcase
		return p;
	endfunction : idle_power

	apis_sel_decode u_decode (
		.input_select (reg_wdata[`APIS_CONV_SEL_MSB:0]),
		.kind         (dec_kind),
		.node_pos     (dec_pos),
		.node_neg     (dec_neg)
	);

	apis_cycle_timer #(
		.CNT_W (CNT_W)
	) u_timer (
		.clk        (clk),
		.reset      (reset),
		.load       (tmr_load),
		.load_value (tmr_value),
		.busy       (),
		.done       (tmr_done)
	);

	// Command byte classification
	assign is_cfg = reg_write && (reg_addr == `APIS_OFS_CMD)
		&& (reg_wdata[`APIS_CFG_ZERO_MSB:`APIS_CFG_ZERO_LSB]
		== `APIS_CFG_ZERO_VAL);
	assign is_conv = reg_write && (reg_addr == `APIS_OFS_CMD)
		&& (reg_wdata[`APIS_CONV_TAG_MSB:`APIS_CONV_TAG_LSB]
		== `APIS_CONV_TAG_VAL);
	assign cap_now = adc_sample_valid ? adc_sample_data : s_q.capt;

	always_comb begin
		s_d              = s_q;
		s_d.sample_start = 1'b0;
		s_d.rdata        = '0;
		tmr_load         = 1'b0;
		tmr_value        = '0;
		go_conv          = 1'b0;
		finish           = 1'b0;
		use_int          = s_q.ref_int || (dec_kind == APIS_MEAS_TEMP);
		fast             = use_int ? (s_q.pm == APIS_PM_STBY_PLUS)
			: (s_q.pm != APIS_PM_SHUTDOWN);
		// Status read clears the sticky flag; a new set below wins
		if (reg_read && (reg_addr == `APIS_OFS_STATUS))
			s_d.bad_sel = 1'b0;
		case (s_q.fsm)
			APIS_ST_IDLE: begin
				if (is_cfg) begin
					s_d.pm          = apis_pm_e'(reg_wdata[
						`APIS_CFG_PM_MSB:`APIS_CFG_PM_LSB]);
					s_d.ref_int     = reg_wdata[`APIS_CFG_REF_BIT];
					s_d.ref_int_sel = s_d.ref_int;
					s_d.pwr         = idle_power(s_d.pm, s_d.ref_int);
					if (s_d.pm == APIS_PM_SHUTDOWN) begin
						s_d.capt         = '0;
						s_d.phase1       = '0;
						s_d.result       = '0;
						s_d.result_valid = 1'b0;
						s_d.is_temp      = 1'b0;
					end
				end else if (is_conv) begin
					if (dec_kind == APIS_MEAS_UNDEF) begin
						s_d.bad_sel = 1'b1;
					end else begin
						s_d.kind         = dec_kind;
						s_d.pos          = dec_pos;
						s_d.neg          = dec_neg;
						s_d.strobe       = 1'b0;
						s_d.bias_high    = 1'b0;
						s_d.ref_int_sel  = use_int;
						s_d.pwr.adc_core = 1'b1;
						s_d.pwr.osc      = 1'b1;
						s_d.pwr.ref_core = 1'b1;
						s_d.pwr.ref_buffer = use_int;
						s_d.pwr.temp_circuit =
							(dec_kind == APIS_MEAS_TEMP);
						if (s_q.pm == APIS_PM_NORMAL) begin
							go_conv = 1'b1;
						end else begin
							s_d.fsm   = APIS_ST_WAKE;
							tmr_load  = 1'b1;
							tmr_value = fast ? CNT_W'(WAKE_FAST_CYC)
								: CNT_W'(WAKE_SLOW_CYC);
						end
					end
				end
			end
			APIS_ST_WAKE: begin
				if (tmr_done)
					go_conv = 1'b1;
			end
			APIS_ST_VOLT: begin
				s_d.capt = cap_now;
				if (tmr_done) begin
					s_d.result  = cap_now;
					s_d.is_temp = 1'b0;
					finish      = 1'b1;
				end
			end
			APIS_ST_TEMP1: begin
				s_d.capt = cap_now;
				if (tmr_done) begin
					s_d.phase1       = cap_now;
					s_d.fsm          = APIS_ST_TEMP2;
					s_d.bias_high    = 1'b1;
					s_d.sample_start = 1'b1;
					tmr_load         = 1'b1;
					tmr_value        = CNT_W'(TEMP_CYC - TEMP_HALF);
				end
			end
			APIS_ST_TEMP2: begin
				s_d.capt = cap_now;
				if (tmr_done) begin
					s_d.result  = cap_now - s_q.phase1;
					s_d.is_temp = 1'b1;
					finish      = 1'b1;
				end
			end
			default: s_d.fsm = APIS_ST_IDLE;
		endcase
		if (go_conv) begin
			s_d.sample_start = 1'b1;
			tmr_load         = 1'b1;
			if (s_d.kind == APIS_MEAS_TEMP) begin
				s_d.fsm   = APIS_ST_TEMP1;
				tmr_value = CNT_W'(TEMP_HALF);
			end else begin
				s_d.fsm   = APIS_ST_VOLT;
				tmr_value = CNT_W'(VOLT_CYC);
			end
		end
		if (finish) begin
			s_d.fsm          = APIS_ST_IDLE;
			s_d.result_valid = 1'b1;
			s_d.strobe       = 1'b1;
			s_d.bias_high    = 1'b0;
			s_d.ref_int_sel  = s_q.ref_int;
			s_d.pwr          = idle_power(s_q.pm, s_q.ref_int);
		end
		if (reg_read) begin
			case (reg_addr)
				`APIS_OFS_CMD:
					s_d.rdata = DATA_W'({s_q.pm, s_q.ref_int});
				`APIS_OFS_STATUS: begin
					s_d.rdata[`APIS_ST_BUSY_BIT]  = (s_q.fsm != APIS_ST_IDLE);
					s_d.rdata[`APIS_ST_VALID_BIT] = s_q.result_valid;
					s_d.rdata[`APIS_ST_BADSEL_BIT] = s_q.bad_sel;
					s_d.rdata[`APIS_ST_REF_BIT]   = s_q.ref_int;
					s_d.rdata[`APIS_ST_PM_MSB:`APIS_ST_PM_LSB] = s_q.pm;
				end
				`APIS_OFS_RESULT: begin
					s_d.rdata[SAMPLE_W-1:0] = s_q.result;
					s_d.rdata[DATA_W-1]     = s_q.is_temp;
				end
				default: s_d.rdata = '0;
			endcase
		end
		s_d.dwell = (s_d.fsm != s_q.fsm) ? '0 : s_q.dwell + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q         <= '0;
			s_q.fsm     <= APIS_ST_IDLE;
			s_q.pm      <= apis_pm_e'(`APIS_RST_PM);
			s_q.ref_int <= `APIS_RST_REF;
			s_q.strobe  <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata         = s_q.rdata;
	assign adc_sample_start  = s_q.sample_start;
	assign bias_step_high    = s_q.bias_high;
	assign ref_internal_sel  = s_q.ref_int_sel;
	assign mux_pos           = s_q.pos;
	assign mux_neg           = s_q.neg;
	assign adc_core_on       = s_q.pwr.adc_core;
	assign osc_on            = s_q.pwr.osc;
	assign ref_buffer_on     = s_q.pwr.ref_buffer;
	assign ref_core_on       = s_q.pwr.ref_core;
	assign temp_circuit_on   = s_q.pwr.temp_circuit;
	assign conversion_strobe = s_q.strobe;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_idle_in(apis_pm_e m);
		(s_q.fsm == APIS_ST_IDLE) && (s_q.pm == m);
	endsequence

	sequence s_conv_accept;
		(s_q.fsm == APIS_ST_IDLE) && is_conv && (dec_kind != APIS_MEAS_UNDEF);
	endsequence

	a_normal_all_on: assert property (
		s_idle_in(APIS_PM_NORMAL) |-> adc_core_on && osc_on && ref_core_on)
		else $error("normal mode circuit powered down");
	a_stbyplus_buffer: assert property (
		s_idle_in(APIS_PM_STBY_PLUS) |-> !adc_core_on && !osc_on
		&& (ref_buffer_on == s_q.ref_int))
		else $error("standby-plus power pattern wrong");
	a_stbyplus_external: assert property (
		s_idle_in(APIS_PM_STBY_PLUS) && !s_q.ref_int |-> !ref_buffer_on)
		else $error("buffer on in standby-plus with external ref");
	a_shutdown_clear: assert property (
		(s_q.fsm == APIS_ST_IDLE) && is_cfg
		&& (reg_wdata[2:1] == 2'h0)
		|=> !s_q.result_valid && (s_q.result == '0) && !ref_core_on)
		else $error("shutdown left data or power on");
	a_undef_ignored: assert property (
		(s_q.fsm == APIS_ST_IDLE) && is_conv && (dec_kind == APIS_MEAS_UNDEF)
		|=> (s_q.fsm == APIS_ST_IDLE) && conversion_strobe && s_q.bad_sel)
		else $error("undefined selector started a conversion");
	a_supply_mux: assert property (
		(s_q.fsm == APIS_ST_VOLT) && (s_q.kind == APIS_MEAS_SUPPLY)
		|-> (s_q.pos == APIS_NODE_VDD_QUARTER) && (s_q.neg == APIS_NODE_GROUND))
		else $error("supply monitor mux wrong");
	a_temp_phase_order: assert property (
		(s_q.fsm == APIS_ST_TEMP1) && tmr_done
		|=> (s_q.fsm == APIS_ST_TEMP2) && bias_step_high && adc_sample_start)
		else $error("second bias step not started");
	a_temp_subtract: assert property (
		(s_q.fsm == APIS_ST_TEMP2) && tmr_done
		|=> s_q.is_temp && (s_q.result == $past(cap_now) - $past(s_q.phase1)))
		else $error("temperature result not the difference");
	a_temp_internal_ref: assert property (
		temp_circuit_on |-> ref_internal_sel && ref_buffer_on)
		else $error("temperature without internal reference");
	a_temp_first_half: assert property (
		(s_q.fsm == APIS_ST_TEMP1) && tmr_done
		|-> s_q.dwell == CNT_W'(TEMP_HALF - 1))
		else $error("first temperature phase length wrong");
	a_temp_second_half: assert property (
		(s_q.fsm == APIS_ST_TEMP2) && tmr_done
		|-> s_q.dwell == CNT_W'(TEMP_CYC - TEMP_HALF - 1))
		else $error("second temperature phase length wrong");
	a_cfg_fields: assert property (
		(s_q.fsm == APIS_ST_IDLE) && is_cfg
		|=> (s_q.pm == $past(reg_wdata[2:1])) && (s_q.ref_int == $past(reg_wdata[0])))
		else $error("config fields not loaded");
	a_conv_starts: assert property (
		s_conv_accept |=> !conversion_strobe && (s_q.fsm != APIS_ST_IDLE))
		else $error("conversion byte did not start");
	a_reset_shutdown: assert property (
		$fell(reset) |-> (s_q.pm == APIS_PM_SHUTDOWN) && !ref_core_on)
		else $error("not in shutdown after reset");
	a_wake_waits: assert property (
		(s_q.fsm == APIS_ST_WAKE) && tmr_done
		|-> s_q.dwell >= CNT_W'(WAKE_FAST_CYC - 1))
		else $error("sampling before wake interval");

endmodule : apis_ctrl

//--- dv/apis_front_model.sv
// Front-end converter model answering sample requests of the block
`timescale 1ns/1ps
module apis_front_model
	import apis_pkg::*;
#(
	parameter int LAT = 2
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        adc_sample_start,
	input  wire logic        bias_step_high,
	input  wire logic        temp_circuit_on,
	input  wire logic [3:0]  mux_pos,
	input  wire logic [3:0]  mux_neg,
	output logic      [11:0] adc_sample_data = 12'hA5A,
	output logic             adc_sample_valid = 1'b0
);
	int          wait_q;
	logic [11:0] hold_q;

	// Sample answers LAT cycles after a request; data toggles otherwise
	always @(posedge clk) begin
		adc_sample_valid <= 1'b0;
		adc_sample_data  <= ~adc_sample_data;
		if (reset) begin
			wait_q <= 0;
		end else if (adc_sample_start) begin
			wait_q <= LAT;
			hold_q <= {mux_pos, mux_neg, 4'h3} +
				((bias_step_high && temp_circuit_on) ? 12'h200 : 12'h000);
		end else if (wait_q == 1) begin
			wait_q           <= 0;
			adc_sample_valid <= 1'b1;
			adc_sample_data  <= hold_q;
		end else if (wait_q > 1) begin
			wait_q <= wait_q - 1;
		end
	end
endmodule : apis_front_model

//--- dv/adc_power_and_input_select_bench.sv
// Self-checking bench of the power and input select control block
`timescale 1ns/1ps
module adc_power_and_input_select_bench;
	import apis_pkg::*;
	localparam int WF = 4;
	localparam int WS = 8;
	localparam int TC = 20;
	localparam int VC = 10;
	logic        clk;
	logic        reset;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_write;
	logic        reg_read;
	logic [15:0] reg_rdata;
	logic [11:0] adc_sample_data;
	logic        adc_sample_valid;
	logic        adc_sample_start;
	logic        bias_step_high;
	logic        ref_internal_sel;
	logic [3:0]  mux_pos;
	logic [3:0]  mux_neg;
	logic        adc_core_on;
	logic        osc_on;
	logic        ref_buffer_on;
	logic        ref_core_on;
	logic        temp_circuit_on;
	logic        conversion_strobe;
	int          mismatches;
	int          total_checks;

	apis_ctrl #(.WAKE_FAST_CYC(WF), .WAKE_SLOW_CYC(WS), .TEMP_CYC(TC),
		.VOLT_CYC(VC)) i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .adc_sample_data(adc_sample_data),
		.adc_sample_valid(adc_sample_valid),
		.adc_sample_start(adc_sample_start), .bias_step_high(bias_step_high),
		.ref_internal_sel(ref_internal_sel), .mux_pos(mux_pos),
		.mux_neg(mux_neg), .adc_core_on(adc_core_on), .osc_on(osc_on),
		.ref_buffer_on(ref_buffer_on), .ref_core_on(ref_core_on),
		.temp_circuit_on(temp_circuit_on),
		.conversion_strobe(conversion_strobe));

	apis_front_model #(.LAT(2)) i_front (.clk(clk), .reset(reset),
		.adc_sample_start(adc_sample_start), .bias_step_high(bias_step_high),
		.temp_circuit_on(temp_circuit_on), .mux_pos(mux_pos),
		.mux_neg(mux_neg), .adc_sample_data(adc_sample_data),
		.adc_sample_valid(adc_sample_valid));

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] exp,
		input string what);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 chk(what, exp, reg_rdata);
	endtask : rd

	function automatic logic [7:0] nodes_of(input logic [3:0] s);
		case (s)
			4'h0: return {APIS_NODE_ANALOG_IN_ZERO, APIS_NODE_ANALOG_IN_COMMON};
			4'h1: return {APIS_NODE_ANALOG_IN_ONE, APIS_NODE_ANALOG_IN_COMMON};
			4'h2: return {APIS_NODE_ANALOG_IN_TWO, APIS_NODE_ANALOG_IN_COMMON};
			4'h3: return {APIS_NODE_ANALOG_IN_THREE, APIS_NODE_ANALOG_IN_COMMON};
			4'h4: return {APIS_NODE_ANALOG_IN_FOUR, APIS_NODE_ANALOG_IN_COMMON};
			4'h6: return {APIS_NODE_ANALOG_IN_COMMON, APIS_NODE_ANALOG_IN_COMMON};
			4'h7: return {APIS_NODE_DIODE_ANODE, APIS_NODE_DIODE_CATHODE};
			4'h8: return {APIS_NODE_ANALOG_IN_ZERO, APIS_NODE_ANALOG_IN_ONE};
			4'h9: return {APIS_NODE_ANALOG_IN_TWO, APIS_NODE_ANALOG_IN_THREE};
			4'hB: return {APIS_NODE_VDD_QUARTER, APIS_NODE_GROUND};
			4'hC: return {APIS_NODE_ANALOG_IN_ZERO, APIS_NODE_ANALOG_IN_ONE};
			4'hD: return {APIS_NODE_ANALOG_IN_TWO, APIS_NODE_ANALOG_IN_THREE};
			default: return 8'h00;
		endcase
	endfunction : nodes_of

	// Starts a conversion, times it and checks sampling and result
	task automatic conv(input logic [3:0] sel, input int wake,
		input logic ref_exp);
		int         n;
		int         first;
		int         starts;
		logic [1:0] bias;
		logic [7:0] nd;
		logic       temp;
		n      = 0;
		first  = -1;
		starts = 0;
		bias   = 2'h0;
		nd     = 8'h00;
		temp   = sel inside {4'h7, 4'hC, 4'hD};
		wr(4'h0, {12'h002, sel});
		#1;
		while (conversion_strobe !== 1'b1 && n < 500) begin
			if (adc_sample_start === 1'b1) begin
				if (first < 0) begin
					first = n;
					nd    = {mux_pos, mux_neg};
					chk("ref", {15'h0, ref_exp}, {15'h0, ref_internal_sel});
					chk("temp on", {15'h0, temp}, {15'h0, temp_circuit_on});
				end
				starts++;
				bias = {bias[0], bias_step_high};
			end
			@(posedge clk);
			#1 n++;
		end
		chk("wake", wake[15:0], first[15:0]);
		chk("cycles", 16'(wake + (temp ? TC : VC)), n[15:0]);
		chk("mux", {8'h00, nodes_of(sel)}, {8'h00, nd});
		chk("starts", temp ? 16'h0009 : 16'h0001,
			temp ? {12'h000, starts[1:0], bias} : starts[15:0]);
		rd(4'h2, temp ? 16'h8200 : {4'h0, nodes_of(sel), 4'h3}, "result");
	endtask : conv

	logic [7:0] cfg_t [7] = '{8'h07, 8'h03, 8'h05, 8'h04, 8'h02, 8'h01, 8'h00};
	logic [3:0] pw_t [7] = '{4'hF, 4'h3, 4'h1, 4'h1, 4'h1, 4'h0, 4'h0};
	int         wake_t [7] = '{0, WF, WS, WF, WF, WS, WS};

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		#(100 * 20000);
		mismatches++;
		close_out();
	end

	initial begin
		reset     = 1'b1;
		reg_addr  = 4'h0;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read  = 1'b0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		#1 chk("power", 16'h0001, {10'h0, adc_core_on, osc_on, ref_buffer_on,
			ref_core_on, temp_circuit_on, conversion_strobe});
		rd(4'h0, 16'h0000, "cmd");
		for (int i = 0; i < 7; i++) begin
			wr(4'h0, {8'h00, cfg_t[i]});
			#1 chk("power", {12'h0, pw_t[i]},
				{12'h0, adc_core_on, osc_on, ref_buffer_on,
				ref_core_on});
			rd(4'h0, {13'h0, cfg_t[i][2:0]}, "cmd");
			conv(4'h0, wake_t[i], cfg_t[i][0]);
		end
		wr(4'h0, 16'h0003);
		conv(4'h7, WF, 1'b1);
		wr(4'h0, 16'h0006);
		conv(4'hC, 0, 1'b1);
		wr(4'h0, 16'h0007);
		for (int s = 0; s < 16; s++) begin
			if (s[3:0] inside {4'h5, 4'hA, 4'hE, 4'hF}) begin
				wr(4'h0, {12'h002, s[3:0]});
				repeat (3) @(posedge clk);
				#1 chk("idle", 16'h0001, {15'h0, conversion_strobe});
				rd(4'h1, 16'h003E, "status");
			end else begin
				conv(s[3:0], 0, 1'b1);
			end
		end
		wr(4'h0, 16'h0000);
		rd(4'h2, 16'h0000, "cleared");
		rd(4'h1, 16'h0000, "status");
		@(posedge clk);
		#1 chk("rdata", 16'h0000, reg_rdata);
		wr(4'h0, 16'h0007);
		wr(4'h0, 16'h0020);
		wr(4'h0, 16'h0000);
		repeat (VC + 2) @(posedge clk);
		rd(4'h0, 16'h0007, "busy cmd");
		wr(4'h0, 16'h000F);
		wr(4'h1, 16'h00FF);
		rd(4'h0, 16'h0007, "bad cfg");
		wr(4'h0, 16'h0050);
		#1 chk("tag", 16'h0001, {15'h0, conversion_strobe});
		rd(4'h5, 16'h0000, "unmapped");
		close_out();
	end
endmodule : adc_power_and_input_select_bench
